/* File: csk_alu.v */
// Eight-bit adder/subtractor with zero, carry, aux carry and overflow flags.
// Assumes carry means borrow on subtraction.
`timescale 1ns/100ps
`include "csk_map.vh"

module csk_alu (
	input  wire [7:0] a_in,
	input  wire [7:0] b_in,
	input  wire       sub_in,
	output wire [7:0] res_out,
	output wire [3:0] flags_out
);

	wire [8:0] full;
	wire [4:0] half;
	wire       ovf;

	// ****************************************************
	// Arithmetic
	// ****************************************************
	assign full = sub_in ? ({1'b0, a_in} - {1'b0, b_in}) : ({1'b0, a_in} + {1'b0, b_in});
	assign half = sub_in ? ({1'b0, a_in[3:0]} - {1'b0, b_in[3:0]})
	                     : ({1'b0, a_in[3:0]} + {1'b0, b_in[3:0]});
	assign res_out = full[7:0];

	// Signed overflow: operand signs differ for subtract, agree for add
	assign ovf = sub_in ? ((a_in[7] ^ b_in[7]) & (a_in[7] ^ full[7]))
	                    : (~(a_in[7] ^ b_in[7]) & (a_in[7] ^ full[7]));

	assign flags_out[`CSK_FLAG_Z]  = (full[7:0] == 8'h00);
	assign flags_out[`CSK_FLAG_C]  = full[8];
	assign flags_out[`CSK_FLAG_AUX] = half[4];
	assign flags_out[`CSK_FLAG_OVF] = ovf;

endmodule

/* File: csk_map.vh */
// Constants for the conditional-skip execution unit.
// Assumes a sequencer that issues one operation at a time and honours the skip answer.
// Behaviour
// - Compare accumulator with an immediate and skip the next instruction when equal.
// - Compare accumulator with a memory byte and skip the next instruction when equal.
// - Compare accumulator with a memory byte and skip the next instruction when unequal.
// - Compare accumulator with an immediate and skip the next instruction when unequal.
// - All compares set zero, carry, aux carry and overflow as accumulator minus operand.
// - IO bit test skips when the selected port bit is zero and leaves flags alone.
// - IO bit test skips when the selected port bit is one and leaves flags alone.
// - Memory bit test skips when the selected bit is zero and leaves flags alone.
// - Memory bit test skips when the selected bit is one and leaves flags alone.
// - Accumulator increment writes back, sets four flags and skips when the result is zero.
// - Accumulator decrement writes back, sets four flags and skips when the result is zero.
// - Memory increment stores back, sets four flags and skips when the stored value is zero.
// - Memory decrement stores back, sets four flags and skips when the stored value is zero.
`ifndef CSK_MAP_VH
`define CSK_MAP_VH

// ****************************************************
// Operation codes
// ****************************************************
`define CSK_OP_W        4
`define CSK_OP_CEQ_IMM  4'h0
`define CSK_OP_CEQ_MEM  4'h1
`define CSK_OP_CNE_MEM  4'h2
`define CSK_OP_CNE_IMM  4'h3
`define CSK_OP_T0_IO    4'h4
`define CSK_OP_T1_IO    4'h5
`define CSK_OP_T0_MEM   4'h6
`define CSK_OP_T1_MEM   4'h7
`define CSK_OP_INC_ACC  4'h8
`define CSK_OP_DEC_ACC  4'h9
`define CSK_OP_INC_MEM  4'hA
`define CSK_OP_DEC_MEM  4'hB

// ****************************************************
// Flag vector bit positions
// ****************************************************
`define CSK_FLAG_Z      0
`define CSK_FLAG_C      1
`define CSK_FLAG_AUX    2
`define CSK_FLAG_OVF    3
`define CSK_FLAG_RST    4'h0

// ****************************************************
// Widths
// ****************************************************
`define CSK_DATA_W      8
`define CSK_ADDR_W      8
`define CSK_BIT_W       3

`endif

/* File: csk_unit.v */
// Execution unit for the conditional-skip instruction group.
// Assumes memory and IO return read data one cycle after the read strobe.
`timescale 1ns/100ps
`include "csk_map.vh"

module csk_unit (
	input  wire        MCLK_IN,
	input  wire        RST_IN,
	input  wire        START_IN,
	input  wire [3:0]  OP_IN,
	input  wire [7:0]  ACC_IN,
	input  wire [7:0]  IMM_IN,
	input  wire [7:0]  ADDR_IN,
	input  wire [2:0]  BIT_SEL_IN,
	input  wire [7:0]  MEM_RDATA_IN,
	input  wire [7:0]  IO_RDATA_IN,
	output reg         BUSY_OUT,
	output reg         DONE_OUT,
	output reg         SKIP_OUT,
	output reg         FLAG_WE_OUT,
	output reg  [3:0]  FLAGS_OUT,
	output reg         ACC_WE_OUT,
	output reg  [7:0]  ACC_WDATA_OUT,
	output reg         MEM_RD_OUT,
	output reg         MEM_WR_OUT,
	output reg  [7:0]  MEM_ADDR_OUT,
	output reg  [7:0]  MEM_WDATA_OUT,
	output reg         IO_RD_OUT,
	output reg  [7:0]  IO_ADDR_OUT
);

	// ****************************************************
	// States
	// ****************************************************
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_WAIT = 2'b01;
	localparam [1:0] ST_LOAD = 2'b10;
	localparam [1:0] ST_EXEC = 2'b11;

	// ****************************************************
	// Decode helpers
	// ****************************************************
	function needs_mem;
		input [3:0] op;
		begin
			needs_mem = (op == `CSK_OP_CEQ_MEM) || (op == `CSK_OP_CNE_MEM) ||
			            (op == `CSK_OP_T0_MEM)  || (op == `CSK_OP_T1_MEM)  ||
			            (op == `CSK_OP_INC_MEM) || (op == `CSK_OP_DEC_MEM);
		end
	endfunction

	function needs_io;
		input [3:0] op;
		begin
			needs_io = (op == `CSK_OP_T0_IO) || (op == `CSK_OP_T1_IO);
		end
	endfunction

	function is_compare;
		input [3:0] op;
		begin
			is_compare = (op <= `CSK_OP_CNE_IMM);
		end
	endfunction

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [3:0] op_q;
	reg [7:0] acc_q;
	reg [7:0] opnd_q;
	reg [2:0] bit_q;

	reg       alu_sub;
	reg [7:0] alu_a;
	reg [7:0] alu_b;
	wire [7:0] alu_res;
	wire [3:0] alu_flags;

	reg        skip_d;
	reg        flag_we_d;
	reg        acc_we_d;
	reg        mem_wr_d;
	wire       bit_val;
	wire       equal;

	assign bit_val = opnd_q[bit_q];
	assign equal   = (acc_q == opnd_q);

	csk_alu u_alu (
		.a_in      (alu_a),
		.b_in      (alu_b),
		.sub_in    (alu_sub),
		.res_out   (alu_res),
		.flags_out (alu_flags)
	);

	// ****************************************************
	// Operand routing and outcome
	// ****************************************************
	always @* begin
		alu_a     = acc_q;
		alu_b     = opnd_q;
		alu_sub   = 1'b1;
		skip_d    = 1'b0;
		flag_we_d = 1'b0;
		acc_we_d  = 1'b0;
		mem_wr_d  = 1'b0;
		case (op_q)
		`CSK_OP_CEQ_IMM: begin
			skip_d    = equal;
			flag_we_d = 1'b1;
		end
		`CSK_OP_CEQ_MEM: begin
			skip_d    = equal;
			flag_we_d = 1'b1;
		end
		`CSK_OP_CNE_MEM: begin
			skip_d    = ~equal;
			flag_we_d = 1'b1;
		end
		`CSK_OP_CNE_IMM: begin
			skip_d    = ~equal;
			flag_we_d = 1'b1;
		end
		`CSK_OP_T0_IO:  skip_d = ~bit_val;
		`CSK_OP_T1_IO:  skip_d = bit_val;
		`CSK_OP_T0_MEM: skip_d = ~bit_val;
		`CSK_OP_T1_MEM: skip_d = bit_val;
		`CSK_OP_INC_ACC: begin
			alu_b     = 8'h01;
			alu_sub   = 1'b0;
			acc_we_d  = 1'b1;
			flag_we_d = 1'b1;
			skip_d    = alu_flags[`CSK_FLAG_Z];
		end
		`CSK_OP_DEC_ACC: begin
			alu_b     = 8'h01;
			acc_we_d  = 1'b1;
			flag_we_d = 1'b1;
			skip_d    = alu_flags[`CSK_FLAG_Z];
		end
		`CSK_OP_INC_MEM: begin
			alu_a     = opnd_q;
			alu_b     = 8'h01;
			alu_sub   = 1'b0;
			mem_wr_d  = 1'b1;
			flag_we_d = 1'b1;
			skip_d    = alu_flags[`CSK_FLAG_Z];
		end
		`CSK_OP_DEC_MEM: begin
			alu_a     = opnd_q;
			alu_b     = 8'h01;
			mem_wr_d  = 1'b1;
			flag_we_d = 1'b1;
			skip_d    = alu_flags[`CSK_FLAG_Z];
		end
		default: begin
			skip_d    = 1'b0;
		end
		endcase
	end

	// ****************************************************
	// Sequencing
	// ****************************************************
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_IDLE: begin
			if (START_IN) begin
				if (needs_mem(OP_IN) || needs_io(OP_IN))
					state_d = ST_WAIT;
				else
					state_d = ST_EXEC;
			end
		end
		ST_WAIT: state_d = ST_LOAD;
		ST_LOAD: state_d = ST_EXEC;
		ST_EXEC: state_d = ST_IDLE;
		default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_q       <= ST_IDLE;
			op_q          <= 4'h0;
			acc_q         <= 8'h00;
			opnd_q        <= 8'h00;
			bit_q         <= 3'h0;
			BUSY_OUT      <= 1'b0;
			DONE_OUT      <= 1'b0;
			SKIP_OUT      <= 1'b0;
			FLAG_WE_OUT   <= 1'b0;
			FLAGS_OUT     <= `CSK_FLAG_RST;
			ACC_WE_OUT    <= 1'b0;
			ACC_WDATA_OUT <= 8'h00;
			MEM_RD_OUT    <= 1'b0;
			MEM_WR_OUT    <= 1'b0;
			MEM_ADDR_OUT  <= 8'h00;
			MEM_WDATA_OUT <= 8'h00;
			IO_RD_OUT     <= 1'b0;
			IO_ADDR_OUT   <= 8'h00;
		end else begin
			state_q     <= state_d;
			DONE_OUT    <= 1'b0;
			SKIP_OUT    <= 1'b0;
			FLAG_WE_OUT <= 1'b0;
			ACC_WE_OUT  <= 1'b0;
			MEM_WR_OUT  <= 1'b0;
			MEM_RD_OUT  <= 1'b0;
			IO_RD_OUT   <= 1'b0;
			BUSY_OUT    <= (state_d != ST_IDLE);
			case (state_q)
			ST_IDLE: begin
				if (START_IN) begin
					op_q   <= OP_IN;
					acc_q  <= ACC_IN;
					opnd_q <= IMM_IN;
					bit_q  <= BIT_SEL_IN;
					if (needs_mem(OP_IN)) begin
						MEM_RD_OUT   <= 1'b1;
						MEM_ADDR_OUT <= ADDR_IN;
					end
					if (needs_io(OP_IN)) begin
						IO_RD_OUT   <= 1'b1;
						IO_ADDR_OUT <= ADDR_IN;
					end
				end
			end
			ST_LOAD: begin
				if (needs_io(op_q))
					opnd_q <= IO_RDATA_IN;
				else
					opnd_q <= MEM_RDATA_IN;
			end
			ST_EXEC: begin
				DONE_OUT    <= 1'b1;
				SKIP_OUT    <= skip_d;
				FLAG_WE_OUT <= flag_we_d;
				if (flag_we_d)
					FLAGS_OUT <= alu_flags;
				// Compares never raise the accumulator or memory write strobe
				ACC_WE_OUT  <= acc_we_d & ~is_compare(op_q);
				MEM_WR_OUT  <= mem_wr_d & ~is_compare(op_q);
				if (acc_we_d)
					ACC_WDATA_OUT <= alu_res;
				if (mem_wr_d)
					MEM_WDATA_OUT <= alu_res;
			end
			default: begin
				BUSY_OUT <= 1'b0;
			end
			endcase
		end
	end

endmodule

/* File: csk_unit_chk.sv */
// Concurrent checks on the ports of the conditional-skip unit.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
module csk_unit_chk (
	input wire       MCLK_IN,
	input wire       RST_IN,
	input wire       START_IN,
	input wire [3:0] OP_IN,
	input wire [7:0] ADDR_IN,
	input wire       BUSY_OUT,
	input wire       DONE_OUT,
	input wire       SKIP_OUT,
	input wire       FLAG_WE_OUT,
	input wire [3:0] FLAGS_OUT,
	input wire       ACC_WE_OUT,
	input wire [7:0] ACC_WDATA_OUT,
	input wire       MEM_RD_OUT,
	input wire       MEM_WR_OUT,
	input wire [7:0] MEM_ADDR_OUT,
	input wire [7:0] MEM_WDATA_OUT,
	input wire       IO_RD_OUT,
	input wire [7:0] IO_ADDR_OUT
);
// ****
// Operation taken
// ****
reg  [3:0] op_q;
wire       quick = OP_IN[3:2] == 2'b11 || OP_IN == 4'h0 || OP_IN == 4'h3 || OP_IN[3:1] == 3'b100;
wire       io_op = OP_IN[3:1] == 3'b010;
always @(posedge MCLK_IN or posedge RST_IN) begin
	if (RST_IN)
		op_q <= 4'h0;
	else if (START_IN && !BUSY_OUT)
		op_q <= OP_IN;
end
default clocking cb @(posedge MCLK_IN);
endclocking
default disable iff (RST_IN);
sequence s_take;
	START_IN && !BUSY_OUT;
endsequence
sequence s_slow;
	!DONE_OUT [*3] ##1 DONE_OUT;
endsequence
a_quick_done: assert property (s_take ##0 quick |=> !DONE_OUT ##1 DONE_OUT)
	else $error("quick op done timing");
a_slow_done: assert property (s_take ##0 !quick |=> s_slow)
	else $error("slow op done timing");
a_mem_fetch: assert property (s_take ##0 !quick && !io_op |=>
	MEM_RD_OUT && !IO_RD_OUT && MEM_ADDR_OUT == $past(ADDR_IN))
	else $error("memory read missing");
a_io_fetch: assert property (s_take ##0 io_op |=>
	IO_RD_OUT && !MEM_RD_OUT && IO_ADDR_OUT == $past(ADDR_IN))
	else $error("port read missing");
a_flags_hold: assert property (!FLAG_WE_OUT |-> $stable(FLAGS_OUT))
	else $error("flags moved unwritten");
a_cmp_skip: assert property (DONE_OUT && op_q[3:2] == 2'b00 |-> FLAG_WE_OUT &&
	SKIP_OUT == (FLAGS_OUT[0] ^ op_q[1]) && !ACC_WE_OUT && !MEM_WR_OUT)
	else $error("compare result wrong");
a_bit_quiet: assert property (DONE_OUT && op_q[3:2] == 2'b01 |->
	!FLAG_WE_OUT && !ACC_WE_OUT && !MEM_WR_OUT)
	else $error("bit test wrote state");
a_step_skip: assert property (DONE_OUT && op_q[3:2] == 2'b10 |-> FLAG_WE_OUT &&
	SKIP_OUT == FLAGS_OUT[0] && (op_q[1] ? MEM_WR_OUT && !ACC_WE_OUT &&
	SKIP_OUT == (MEM_WDATA_OUT == 8'h00) : ACC_WE_OUT && !MEM_WR_OUT &&
	SKIP_OUT == (ACC_WDATA_OUT == 8'h00)))
	else $error("step result wrong");
a_pulse_done: assert property (SKIP_OUT || ACC_WE_OUT || MEM_WR_OUT |-> DONE_OUT)
	else $error("effect outside done");
endmodule
bind csk_unit csk_unit_chk u_csk_unit_chk (.*);

/* File: tb_top.sv */
// Self-checking bench of the conditional-skip unit.
// Assumes csk_unit and its checker are compiled first.
`timescale 1ns/100ps
module tb_top;
reg        clk = 1'b0;
reg        rst = 1'b1;
reg        start = 1'b0;
reg  [3:0] op = 4'h0;
reg  [7:0] acc = 8'h00, imm = 8'h00, addr = 8'h00, mrd = 8'h00, iord = 8'h00;
reg  [2:0] bsel = 3'h0;
wire       busy, done, skip, fwe, accwe, mrdo, mwr, iordo;
wire [3:0] flags;
wire [7:0] accw, maddr, mwd, ioaddr;
integer    n_mismatch = 0, n_compared = 0, seed = 32'h9AB4, k, r;
reg [15:0] exp_q[$];
reg [31:0] tbl [0:5] = '{32'h55555500, 32'h01800107, 32'hFFFFFF07, 32'h80108003,
	32'h7F0F7F04, 32'h10010002};
wire [15:0] seen = {skip, fwe, fwe ? flags : 4'h0, accwe, mwr, accwe ? accw : mwr ? mwd : 8'h00};
wire [9:0] fetch_seen = {mrdo, iordo, mrdo ? maddr : ioaddr};
wire [9:0] fetch_want = {op[3:1] != 3'b010, op[3:1] == 3'b010, addr};
always #5 clk = ~clk;
csk_unit u_csk_unit (.MCLK_IN(clk), .RST_IN(rst), .START_IN(start), .OP_IN(op), .ACC_IN(acc),
	.IMM_IN(imm), .ADDR_IN(addr), .BIT_SEL_IN(bsel), .MEM_RDATA_IN(mrd), .IO_RDATA_IN(iord),
	.BUSY_OUT(busy), .DONE_OUT(done), .SKIP_OUT(skip), .FLAG_WE_OUT(fwe), .FLAGS_OUT(flags),
	.ACC_WE_OUT(accwe), .ACC_WDATA_OUT(accw), .MEM_RD_OUT(mrdo), .MEM_WR_OUT(mwr),
	.MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwd), .IO_RD_OUT(iordo), .IO_ADDR_OUT(ioaddr));
// ****
// Checking
// ****
task check(input string nm, input [31:0] got, input [31:0] want);
	begin
		n_compared = n_compared + 1;
		if (got !== want) begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH %s expected %h seen %h", nm, want, got);
		end
	end
endtask
function [15:0] model(input [3:0] o, input [7:0] a, input [7:0] im, input [7:0] d,
	input [2:0] b);
	reg [8:0] s;
	reg [4:0] h;
	reg [7:0] x, y;
	reg       sb, ovf, z;
	begin
		x = (o[3] && o[1]) ? d : a;
		y = o[3] ? 8'h01 : (o == 4'h0 || o == 4'h3) ? im : d;
		sb = !o[3] || o[0];
		s = sb ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
		h = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} : {1'b0, x[3:0]} + {1'b0, y[3:0]};
		ovf = (x[7] ^ y[7] ^ !sb) & (s[7] ^ x[7]);
		z = s[7:0] == 8'h00;
		case (o[3:2])
			2'b00: model = {z ^ o[1], 1'b1, ovf, h[4], s[8], z, 2'b00, 8'h00};
			2'b01: model = {d[b] ^ !o[0], 1'b0, 4'h0, 2'b00, 8'h00};
			2'b10: model = {z, 1'b1, ovf, h[4], s[8], z, !o[1], o[1], s[7:0]};
			default: model = 16'h0000;
		endcase
	end
endfunction
always @(posedge clk) begin
	if (done === 1'b1)
		check("result", seen, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
	if (mrdo === 1'b1 || iordo === 1'b1)
		check("fetch", fetch_seen, fetch_want);
end
// ****
// Stimulus
// ****
task run(input [3:0] o, input [7:0] a, input [7:0] im, input [7:0] d, input [2:0] b,
	input bb);
	integer lat;
	begin
		lat = (o[3:2] == 2'b11 || o == 4'h0 || o == 4'h3 || o[3:1] == 3'b100) ? 2 : 4;
		exp_q.push_back(model(o, a, im, d, b));
		start <= 1'b1;
		op <= o;
		acc <= a;
		imm <= im;
		bsel <= b;
		addr <= a ^ d;
		mrd <= (o[3:1] == 3'b010) ? ~d : d;
		iord <= (o[3:1] == 3'b010) ? d : ~d;
		@(posedge clk) start <= (a[0] ^ d[0]) && lat == 4;
		@(posedge clk);
		// Back-to-back quick ops: next call raises start on this edge
		if (lat == 4 || !bb)
			start <= 1'b0;
		repeat (lat - 2) @(posedge clk);
		if (!bb)
			@(posedge clk);
	end
endtask
task conclude;
	begin
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
endtask
initial begin
	#200000;
	n_mismatch = n_mismatch + 1;
	conclude;
end
initial begin
	repeat (8) @(posedge clk);
	rst <= 1'b0;
	for (k = 0; k < 96; k = k + 1)
		run(k[3:0], tbl[k/16][31:24], tbl[k/16][23:16], tbl[k/16][15:8], tbl[k/16][2:0], k[0]);
	$display("Test corners done");
	start <= 1'b1;
	op <= 4'hB;
	@(posedge clk) start <= 1'b0;
	@(posedge clk) rst <= 1'b1;
	@(posedge clk) rst <= 1'b0;
	#1 check("after reset", {busy, done, mwr, fwe, flags}, 8'h00);
	@(posedge clk);
	$display("Test reset done");
	for (k = 0; k < 300; k = k + 1) begin
		r = $random(seed);
		run(r[3:0], r[11:4], r[19:12], r[27:20], r[30:28], r[31]);
	end
	repeat (6) @(posedge clk);
	check("pending", exp_q.size(), 0);
	$display("Test random done");
	conclude;
end
endmodule
